// *** fnars_map.vh ***
// Constants for the fieldbus node address and rate selector.
// Assumes a 40 MHz system clock and 32-bit APB register access.
`ifndef FNARS_MAP_VH
`define FNARS_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FNARS_OFF_STAGE_ADDR  12'h000
`define FNARS_OFF_STAGE_RATE  12'h004
`define FNARS_OFF_CONTROL     12'h008
`define FNARS_OFF_STATUS      12'h00c
`define FNARS_OFF_SWITCHES    12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FNARS_CTL_SAVE_BIT     0
`define FNARS_CTL_RESTART_BIT  1
`define FNARS_ST_RATE_LSB      8
`define FNARS_ST_ADDR_SRC_BIT  16
`define FNARS_ST_RATE_SRC_BIT  17
`define FNARS_ST_VALID_BIT     31
`define FNARS_SW_UNITS_LSB     0
`define FNARS_SW_TENS_LSB      4
`define FNARS_SW_RATE_LSB      8

// ----------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------
`define FNARS_ADDR_MAX         7'h3f
`define FNARS_RATE_MAX         4'h2
`define FNARS_RATE_125K        2'h0
`define FNARS_RATE_250K        2'h1
`define FNARS_RATE_500K        2'h2
`define FNARS_RST_STAGE_ADDR   6'h3f
`define FNARS_RST_STAGE_RATE   2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FNARS_CLK_MHZ          40
`define FNARS_SETTLE_NS        200
`define FNARS_SETTLE_CYC       ((`FNARS_SETTLE_NS * `FNARS_CLK_MHZ + 999) / 1000)

`endif

// *** fnars_nv_model.sv ***
// Nonvolatile parameter store model beside the selector.
// Assumes the save strobe is a one-cycle pulse on the same clock.
`default_nettype none
module fnars_nv_model #(
  parameter logic [5:0] INIT_ADDR = 6'h15,
  parameter logic [1:0] INIT_RATE = 2'h1
) (
  input  wire logic       i_clk,
  input  wire logic       i_save,
  input  wire logic [5:0] i_addr,
  input  wire logic [1:0] i_rate,
  output var  logic [5:0] o_addr,
  output var  logic [1:0] o_rate
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contents survive reset: nothing here looks at it
  initial
  begin
    o_addr = INIT_ADDR;
    o_rate = INIT_RATE;
  end
  always @(posedge i_clk)
    if (i_save)
    begin
      o_addr <= i_addr;
      o_rate <= i_rate;
    end
endmodule // fnars_nv_model
`default_nettype wire

// *** fnars_props.sv ***
// Checker for the node address and rate selector, watching top ports only.
// Assumes switches and stored values stay still around each latch.
`default_nettype none
module fnars_props (
  input wire logic        i_clk, i_rst_n, i_psel, i_penable, i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_tens_switch, i_units_switch, i_rate_switch,
  input wire logic [5:0]  i_nv_addr, o_node_addr,
  input wire logic [1:0]  i_nv_rate, o_rate_code,
  input wire logic        o_pready, o_nv_save, o_cfg_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sw_val;
  logic       sw_ok;
  // Digits above nine count as out of range, like values above 63
  assign sw_val = i_tens_switch * 8'h0a + i_units_switch;
  assign sw_ok  = i_tens_switch < 4'ha && i_units_switch < 4'ha && sw_val < 8'h40;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ready_high_a: assert property (o_pready)
    else $error("pready low");
  addr_hold_a: assert property (o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_node_addr))
    else $error("node address moved while valid");
  rate_hold_a: assert property (o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_rate_code))
    else $error("rate code moved while valid");
  sw_addr_a: assert property ($rose(o_cfg_valid) && sw_ok |-> o_node_addr == sw_val[5:0])
    else $error("switch address not used");
  nv_addr_a: assert property ($rose(o_cfg_valid) && !sw_ok |-> o_node_addr == i_nv_addr)
    else $error("stored address not used");
  sw_rate_a: assert property ($rose(o_cfg_valid) && i_rate_switch < 4'h3
    |-> o_rate_code == i_rate_switch[1:0])
    else $error("switch rate not used");
  nv_rate_a: assert property ($rose(o_cfg_valid) && i_rate_switch > 4'h2
    |-> o_rate_code == (i_nv_rate == 2'h3 ? 2'h0 : i_nv_rate))
    else $error("stored rate not used");
  save_pulse_a: assert property (i_psel && i_penable && i_pwrite && i_paddr == 12'h008
    && i_pwdata[0] |=> o_nv_save ##1 !o_nv_save)
    else $error("save pulse wrong");
endmodule // fnars_props
`default_nettype wire

// *** fnars_sync.v ***
// Two-flop synchroniser for a vector of slow, quasi-static pin levels.
// Assumes every bit is a level that stays put for many clock cycles.
`default_nettype none

module fnars_sync #(
  parameter W = 12
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_rst_n,
  // Pin side
  input  wire [W-1:0] i_async,
  // Synchronised side
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // fnars_sync

`default_nettype wire

// *** fnars_tb.sv ***
// Self-checking bench for the node address and rate selector.
// Assumes the design files and the store model are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] t, u, r; logic [5:0] a; logic [1:0] c; logic as, rs;} fnars_row_t;
  fnars_row_t rows [6] = '{'{4'h0, 4'h0, 4'h0, 6'h00, 2'h0, 1'b0, 1'b0},
    '{4'h6, 4'h3, 4'h1, 6'h3f, 2'h1, 1'b0, 1'b0}, '{4'h6, 4'h4, 4'h2, 6'h15, 2'h2, 1'b1, 1'b0},
    '{4'h1, 4'h0, 4'h3, 6'h0a, 2'h1, 1'b0, 1'b1}, '{4'h0, 4'hc, 4'h0, 6'h15, 2'h0, 1'b1, 1'b0},
    '{4'h9, 4'h9, 4'hf, 6'h15, 2'h1, 1'b1, 1'b1}};
  logic        i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic [3:0]  i_tens_switch = 4'h0, i_units_switch = 4'h0, i_rate_switch = 4'h0;
  wire  [5:0]  i_nv_addr, o_nv_addr, o_node_addr;
  wire  [1:0]  i_nv_rate, o_nv_rate, o_rate_code;
  wire         o_pready, o_pslverr, o_nv_save, o_cfg_valid;
  wire  [31:0] o_prdata;
  int          errors = 0, n_compared = 0;
  always #12.5 i_clk = ~i_clk;
  fnars_top dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_pready, .o_prdata, .o_pslverr, .i_tens_switch, .i_units_switch, .i_rate_switch,
    .i_nv_addr, .i_nv_rate, .o_nv_save, .o_nv_addr, .o_nv_rate, .o_node_addr, .o_rate_code,
    .o_cfg_valid);
  fnars_nv_model store (.i_clk, .i_save(o_nv_save), .i_addr(o_nv_addr), .i_rate(o_nv_rate),
    .o_addr(i_nv_addr), .o_rate(i_nv_rate));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic restart();
    int n;
    apb(1'b1, 12'h008, 32'h2);
    repeat (3) @(posedge i_clk);
    #1 check("valid low", 32'h0, o_cfg_valid);
    for (n = 0; n < 30 && o_cfg_valid !== 1'b1; n++) @(posedge i_clk);
    #1 check("valid", 32'h1, o_cfg_valid);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check("stage addr", 32'h3f, rd);
    apb(1'b0, 12'h004, 32'h0);
    check("stage rate", 32'h0, rd);
    foreach (rows[i])
    begin
      @(posedge i_clk);
      {i_tens_switch, i_units_switch, i_rate_switch} <= {rows[i].t, rows[i].u, rows[i].r};
      restart();
      check("node addr", rows[i].a, o_node_addr);
      check("rate code", rows[i].c, o_rate_code);
      apb(1'b0, 12'h00c, 32'h0);
      check("status", {1'b1, 13'h0, rows[i].rs, rows[i].as, 6'h0, rows[i].c, 2'h0, rows[i].a}, rd);
      apb(1'b0, 12'h010, 32'h0);
      check("switches", {20'h0, rows[i].r, rows[i].t, rows[i].u}, rd);
    end
    apb(1'b1, 12'h000, 32'h40);
    check("addr over", 32'h1, err);
    apb(1'b1, 12'h000, 32'h2a);
    check("addr ok", 32'h0, err);
    apb(1'b1, 12'h004, 32'h3);
    check("rate over", 32'h1, err);
    apb(1'b1, 12'h004, 32'h2);
    check("rate ok", 32'h0, err);
    apb(1'b1, 12'h008, 32'h1);
    repeat (3) @(posedge i_clk);
    check("saved addr", 32'h2a, i_nv_addr);
    check("saved rate", 32'h2, i_nv_rate);
    check("no early addr", 32'h15, o_node_addr);
    restart();
    check("new addr", 32'h2a, o_node_addr);
    check("new rate", 32'h2, o_rate_code);
    @(posedge i_clk);
    {i_tens_switch, i_units_switch, i_rate_switch} <= {4'h0, 4'h5, 4'h0};
    repeat (4) @(posedge i_clk);
    apb(1'b1, 12'h000, 32'h11);
    check("addr locked", 32'h1, err);
    apb(1'b1, 12'h004, 32'h1);
    check("rate locked", 32'h1, err);
    check("addr held", 32'h2a, o_node_addr);
    apb(1'b0, 12'h014, 32'h0);
    check("unmapped", 32'h1, err);
    apb(1'b1, 12'h00c, 32'h0);
    check("status ro", 32'h1, err);
    // Mid-run reset: storage keeps its contents, switches read 05 and rate 0
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    #1 check("reset valid", 32'h0, o_cfg_valid);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check("reset stage", 32'h3f, rd);
    for (int n = 0; n < 30 && o_cfg_valid !== 1'b1; n++) @(posedge i_clk);
    #1 check("relatch valid", 32'h1, o_cfg_valid);
    check("relatch addr", 32'h05, o_node_addr);
    check("relatch rate", 32'h0, o_rate_code);
    test_done();
  end
  initial
  begin
    #100us;
    errors++;
    test_done();
  end
endmodule // tb
bind fnars_top fnars_props u_props (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .i_tens_switch, .i_units_switch, .i_rate_switch, .i_nv_addr, .o_node_addr,
  .i_nv_rate, .o_rate_code, .o_pready, .o_nv_save, .o_cfg_valid);
`default_nettype wire

// *** fnars_top.v ***
// Node address and bit rate selector for a fieldbus expansion card.
// Assumes rotary switches on pins, a same-clock nonvolatile store and an APB master.
//
// The APB slave port and the address map were left to the implementer.
`include "fnars_map.vh"
`default_nettype none

module fnars_top (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  // Rotary switches (pins)
  input  wire [3:0]  i_tens_switch,
  input  wire [3:0]  i_units_switch,
  input  wire [3:0]  i_rate_switch,
  // Nonvolatile parameter store
  input  wire [5:0]  i_nv_addr,
  input  wire [1:0]  i_nv_rate,
  output reg         o_nv_save,
  output reg  [5:0]  o_nv_addr,
  output reg  [1:0]  o_nv_rate,
  // Fieldbus controller
  output reg  [5:0]  o_node_addr,
  output reg  [1:0]  o_rate_code,
  output reg         o_cfg_valid
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A digit above nine is no decimal digit; forcing 127 sends it to storage
  // and keeps two large digits from wrapping the 7-bit sum back into range
  function [6:0] fnars_bcd;
    input [3:0] tens;
    input [3:0] units;
    begin
      if (tens > 4'h9 || units > 4'h9)
        fnars_bcd = 7'h7f;
      else
        fnars_bcd = {tens, 3'h0} + {2'h0, tens, 1'h0} + {3'h0, units};
    end
  endfunction

  function fnars_rate_ok;
    input [3:0] code;
    begin
      fnars_rate_ok = (code <= `FNARS_RATE_MAX);
    end
  endfunction

  // ----------------------------------------------------------------
  // Switch synchronisation
  // ----------------------------------------------------------------
  wire [11:0] sw_sync;

  fnars_sync #(
    .W (12)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_rate_switch, i_tens_switch, i_units_switch}),
    .o_sync  (sw_sync)
  );

  wire [3:0] units_s  = sw_sync[`FNARS_SW_UNITS_LSB +: 4];
  wire [3:0] tens_s   = sw_sync[`FNARS_SW_TENS_LSB +: 4];
  wire [3:0] rate_s   = sw_sync[`FNARS_SW_RATE_LSB +: 4];
  wire [6:0] sw_value = fnars_bcd(tens_s, units_s);
  wire       addr_use_stored = (sw_value > `FNARS_ADDR_MAX);
  wire       rate_use_stored = !fnars_rate_ok(rate_s);

  // ----------------------------------------------------------------
  // Start-up latch sequencer
  // ----------------------------------------------------------------
  localparam [1:0] ST_SETTLE = 2'h0;
  localparam [1:0] ST_LATCH  = 2'h1;
  localparam [1:0] ST_RUN    = 2'h2;
  localparam integer SETTLE_I = `FNARS_SETTLE_CYC;
  localparam [7:0] SETTLE_N  = SETTLE_I[7:0];

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] cnt_reg;
  reg       restart_req;
  reg       addr_src_reg;
  reg       rate_src_reg;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_SETTLE:
        if (cnt_reg == 8'h00)
          state_next = ST_LATCH;
      ST_LATCH:
        state_next = ST_RUN;
      ST_RUN:
        if (restart_req)
          state_next = ST_SETTLE;
      default:
        state_next = ST_SETTLE;
    endcase
  end

  // Waiting lets the synchroniser fill with real switch levels first
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg    <= ST_SETTLE;
      cnt_reg      <= SETTLE_N;
      o_node_addr  <= 6'h00;
      o_rate_code  <= `FNARS_RATE_125K;
      o_cfg_valid  <= 1'b0;
      addr_src_reg <= 1'b0;
      rate_src_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_SETTLE && cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
      if (state_next == ST_SETTLE && state_reg == ST_RUN)
      begin
        cnt_reg     <= SETTLE_N;
        o_cfg_valid <= 1'b0;
      end
      if (state_reg == ST_LATCH)
      begin
        o_cfg_valid  <= 1'b1;
        addr_src_reg <= addr_use_stored;
        rate_src_reg <= rate_use_stored;
        if (addr_use_stored)
          o_node_addr <= i_nv_addr;
        else
          o_node_addr <= sw_value[5:0];
        if (!rate_use_stored)
          o_rate_code <= rate_s[1:0];
        else if (fnars_rate_ok({2'h0, i_nv_rate}))
          o_rate_code <= i_nv_rate;
        else
          o_rate_code <= `FNARS_RATE_125K;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  reg  [5:0] stage_addr_reg;
  reg  [1:0] stage_rate_reg;
  wire       setup_ph  = i_psel && !i_penable;
  wire       access_ph = i_psel && i_penable;
  wire       wr_en     = access_ph && i_pwrite && !o_pslverr;

  assign o_pready = 1'b1;

  // Staged writes are refused unless the switches defer to storage
  reg        err_next;
  reg [31:0] rd_next;
  always @*
  begin
    err_next = 1'b0;
    rd_next  = 32'h0000_0000;
    case (i_paddr)
      `FNARS_OFF_STAGE_ADDR:
      begin
        rd_next  = {26'h0, stage_addr_reg};
        err_next = i_pwrite && (!addr_use_stored ||
                   i_pwdata[31:0] > {25'h0, `FNARS_ADDR_MAX});
      end
      `FNARS_OFF_STAGE_RATE:
      begin
        rd_next  = {30'h0, stage_rate_reg};
        err_next = i_pwrite && (!rate_use_stored ||
                   i_pwdata[31:0] > {28'h0, `FNARS_RATE_MAX});
      end
      `FNARS_OFF_CONTROL:
        rd_next = 32'h0000_0000;
      `FNARS_OFF_STATUS:
      begin
        rd_next[5:0] = o_node_addr;
        rd_next[`FNARS_ST_RATE_LSB +: 2] = o_rate_code;
        rd_next[`FNARS_ST_ADDR_SRC_BIT]  = addr_src_reg;
        rd_next[`FNARS_ST_RATE_SRC_BIT]  = rate_src_reg;
        rd_next[`FNARS_ST_VALID_BIT]     = o_cfg_valid;
        err_next = i_pwrite;
      end
      `FNARS_OFF_SWITCHES:
      begin
        rd_next  = {20'h0, sw_sync};
        err_next = i_pwrite;
      end
      default:
        err_next = 1'b1;
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prdata       <= 32'h0000_0000;
      o_pslverr      <= 1'b0;
      stage_addr_reg <= `FNARS_RST_STAGE_ADDR;
      stage_rate_reg <= `FNARS_RST_STAGE_RATE;
      o_nv_save      <= 1'b0;
      o_nv_addr      <= 6'h00;
      o_nv_rate      <= `FNARS_RATE_125K;
      restart_req    <= 1'b0;
    end
    else
    begin
      o_nv_save   <= 1'b0;
      restart_req <= 1'b0;
      if (setup_ph)
      begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_next;
        o_pslverr <= err_next;
      end
      else if (!i_psel)
        o_pslverr <= 1'b0;
      if (wr_en && i_paddr == `FNARS_OFF_STAGE_ADDR)
        stage_addr_reg <= i_pwdata[5:0];
      if (wr_en && i_paddr == `FNARS_OFF_STAGE_RATE)
        stage_rate_reg <= i_pwdata[1:0];
      if (wr_en && i_paddr == `FNARS_OFF_CONTROL)
      begin
        // Saving only fills storage; the outputs wait for a restart
        if (i_pwdata[`FNARS_CTL_SAVE_BIT])
        begin
          o_nv_save <= 1'b1;
          o_nv_addr <= stage_addr_reg;
          o_nv_rate <= stage_rate_reg;
        end
        if (i_pwdata[`FNARS_CTL_RESTART_BIT])
          restart_req <= 1'b1;
      end
    end
  end

endmodule // fnars_top

`default_nettype wire
